// ---- hdl/irqc_regs.sv ----
`timescale 1ns/1ps
module irqc_regs
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Raw event pulses from the controller, one bit per flag
    input wire logic [31:0] event_set,
    // Flag clear strobes from the status register owner
    input wire logic [31:0] event_clear,
    // FIFO fill figures
    input wire logic [7:0] tx_free_blocks,
    input wire logic [7:0] tx_status_used,
    input wire logic [7:0] rx_status_used,
    // Receive data FIFO read strobe, one per DWORD
    input wire logic rx_dword_read,
    // Last DWORD of a buffer is being read
    input wire logic rx_buffer_last,
    // Event flags and interrupt
    output logic [31:0] irq_event_flags,
    output logic irq_out,
    // Receive engine controls
    output logic rx_fifo_discard,
    output logic [1:0] rx_end_align,
    output logic [4:0] rx_leading_byte_offset,
    output logic [2:0] rx_pad_dwords,
    output logic [11:0] rx_dword_countdown
);
    import irqc_pkg::*;

    // All state in one record
    typedef struct packed {
        logic [31:0] mask;
        logic [7:0] tx_space_level;
        logic [7:0] tx_stat_level;
        logic [7:0] rx_stat_level;
        logic [1:0] align;
        logic [11:0] count;
        logic count_run;
        logic discard;
        logic [4:0] offset;
        logic [2:0] dword_pos;
        logic [2:0] pad;
        logic [31:0] flags;
        logic irq;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } irqc_state_t;

    irqc_state_t st_reg; // Current state
    irqc_state_t st_next; // Next state

    // Offset decode shared by read and write paths
    function automatic logic irqc_mapped(input logic [7:0] a);
        irqc_mapped = (a == IRQC_MASK_OFS) || (a == IRQC_PROBE_OFS) ||
                      (a == IRQC_LEVEL_OFS) || (a == IRQC_RXCFG_OFS);
    endfunction

    logic acc; // Setup phase seen, answer next cycle
    logic wr; // Write taking effect this edge
    logic [31:0] ev; // Events including level events
    logic [2:0] granule; // Padding granule mask
    logic [2:0] pos_after; // DWORD position after this read

    assign acc = psel && !penable;
    assign wr = psel && penable && pready && pwrite && irqc_mapped(paddr);

    // Next state
    always_comb
    begin
        st_next = st_reg;
        ev = event_set;
        // Level events compare strictly greater than
        ev[IRQC_EV_TXSPACE] = tx_free_blocks > st_reg.tx_space_level;
        ev[IRQC_EV_TXSTAT] = tx_status_used > st_reg.tx_stat_level;
        ev[IRQC_EV_RXSTAT] = rx_status_used > st_reg.rx_stat_level;
        ev[IRQC_EV_DMADONE] = 1'b0;
        st_next.discard = 1'b0;
        // Countdown per DWORD read; done when it reaches zero
        if (rx_dword_read && st_reg.count_run)
        begin
            st_next.count = st_reg.count - 12'h001;
            if (st_reg.count == 12'h001)
            begin
                st_next.count_run = 1'b0;
                ev[IRQC_EV_DMADONE] = 1'b1;
            end
        end
        // Padding length on the final transfer of a buffer
        case (st_reg.align)
            IRQC_ALIGN_16: granule = IRQC_PAD16_MASK;
            IRQC_ALIGN_32: granule = IRQC_PAD32_MASK;
            default: granule = 3'h0; // 4-byte and reserved: no pad
        endcase
        pos_after = st_reg.dword_pos + 3'h1;
        if (rx_dword_read)
        begin
            if (rx_buffer_last)
            begin
                // Pad to next boundary, counted from buffer start
                st_next.pad = (~pos_after + 3'h1) & granule;
                st_next.dword_pos = 3'h0;
            end
            else
            begin
                st_next.pad = 3'h0;
                st_next.dword_pos = pos_after;
            end
        end
        // Set wins over clear, independent of the mask
        st_next.flags = (st_reg.flags & ~event_clear) | ev;
        // Enabled flags OR onto the line
        st_next.irq = |(st_next.flags & st_reg.mask);
        // Register writes
        if (wr)
        begin
            if (paddr == IRQC_MASK_OFS)
            begin
                // Reserved bits stay zero
                st_next.mask = pwdata & IRQC_MASK_RW;
            end
            else if (paddr == IRQC_LEVEL_OFS)
            begin
                st_next.tx_space_level = pwdata[IRQC_TXSPACE_LSB +: 8];
                st_next.tx_stat_level = pwdata[IRQC_TXSTAT_LSB +: 8];
                st_next.rx_stat_level = pwdata[IRQC_RXSTAT_LSB +: 8];
            end
            else if (paddr == IRQC_RXCFG_OFS)
            begin
                st_next.align = pwdata[IRQC_ALIGN_LSB +: 2];
                // A write replaces the running count
                st_next.count = pwdata[IRQC_COUNT_LSB +: 12];
                st_next.count_run = pwdata[IRQC_COUNT_LSB +: 12] != 12'h000;
                st_next.discard = pwdata[IRQC_DISCARD_BIT];
                // A purge drops any half-read buffer, so padding restarts
                if (pwdata[IRQC_DISCARD_BIT])
                    st_next.dword_pos = 3'h0;
                // Offset is taken as written; it is used from the next read
                st_next.offset = pwdata[IRQC_OFFSET_LSB +: 5];
            end
        end
        // APB answer one cycle after setup; no wait states
        st_next.ready = acc;
        st_next.err = acc && !irqc_mapped(paddr);
        st_next.rdata = 32'h00000000;
        if (acc && !pwrite)
        begin
            if (paddr == IRQC_MASK_OFS)
                st_next.rdata = st_reg.mask;
            else if (paddr == IRQC_PROBE_OFS)
                st_next.rdata = IRQC_PROBE_VAL;
            else if (paddr == IRQC_LEVEL_OFS)
                st_next.rdata = {st_reg.tx_space_level, st_reg.tx_stat_level,
                                 8'h00, st_reg.rx_stat_level};
            else if (paddr == IRQC_RXCFG_OFS)
                // Reserved fields and the self-clearing bit read zero
                st_next.rdata = {st_reg.align, 2'h0, st_reg.count, 3'h0,
                                 st_reg.offset, 8'h00};
        end
    end

    // State register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= '0;
            st_reg.mask <= IRQC_MASK_RST;
            st_reg.tx_space_level <= IRQC_TXSPACE_RST;
            st_reg.tx_stat_level <= IRQC_TXSTAT_RST;
            st_reg.rx_stat_level <= IRQC_RXSTAT_RST;
            st_reg.align <= IRQC_ALIGN_4;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops
    assign prdata = st_reg.rdata;
    assign pready = st_reg.ready;
    assign pslverr = st_reg.err;
    assign irq_event_flags = st_reg.flags;
    assign irq_out = st_reg.irq;
    assign rx_fifo_discard = st_reg.discard;
    assign rx_end_align = st_reg.align;
    assign rx_leading_byte_offset = st_reg.offset;
    assign rx_pad_dwords = st_reg.pad;
    assign rx_dword_countdown = st_reg.count;

    // Mask reserved bits never set
    mask_reserved_a: assert property (@(posedge clock) disable iff (rst)
        (st_reg.mask & ~IRQC_MASK_RW) == 32'h00000000)
        else $error("reserved mask bit set");

    // Probe reads pattern one cycle after setup
    probe_read_a: assert property (@(posedge clock) disable iff (rst)
        (acc && !pwrite && paddr == IRQC_PROBE_OFS) |=> (pready && prdata == IRQC_PROBE_VAL))
        else $error("probe pattern wrong");

    // Interrupt follows enabled flags
    irq_or_a: assert property (@(posedge clock) disable iff (rst)
        irq_out == |(irq_event_flags & $past(st_reg.mask)))
        else $error("interrupt not OR of enabled flags");

    // Flags set even when masked
    flag_set_a: assert property (@(posedge clock) disable iff (rst)
        (event_set[0] && !st_reg.mask[0]) |=> irq_event_flags[0])
        else $error("masked event lost");

    // Tx space event when above level
    tx_space_a: assert property (@(posedge clock) disable iff (rst)
        (tx_free_blocks > st_reg.tx_space_level) |=> irq_event_flags[IRQC_EV_TXSPACE])
        else $error("tx space event missing");

    // Discard pulse lasts one cycle after write
    discard_pulse_a: assert property (@(posedge clock) disable iff (rst)
        (wr && paddr == IRQC_RXCFG_OFS && pwdata[IRQC_DISCARD_BIT])
        |=> rx_fifo_discard ##1 !rx_fifo_discard)
        else $error("discard not one pulse");

    // Count decrements on read
    count_dec_a: assert property (@(posedge clock) disable iff (rst)
        (rx_dword_read && st_reg.count_run && !wr)
        |=> rx_dword_countdown == $past(rx_dword_countdown) - 12'h001)
        else $error("countdown did not step");

    // Written count reloads
    count_load_a: assert property (@(posedge clock) disable iff (rst)
        (wr && paddr == IRQC_RXCFG_OFS)
        |=> rx_dword_countdown == $past(pwdata[IRQC_COUNT_LSB +: 12]))
        else $error("count not reloaded");

    // Setup cycle of a read of the receive configuration
    sequence rxcfg_read_s;
        acc && !pwrite && paddr == IRQC_RXCFG_OFS;
    endsequence

    // Setup cycle of a read of the level register
    sequence level_read_s;
        acc && !pwrite && paddr == IRQC_LEVEL_OFS;
    endsequence

    // Write to the receive configuration taking effect
    sequence rxcfg_write_s;
        wr && paddr == IRQC_RXCFG_OFS;
    endsequence

    // Last DWORD of a buffer read under 32-byte alignment
    sequence last32_s;
        rx_dword_read && rx_buffer_last && rx_end_align == IRQC_ALIGN_32;
    endsequence

    // Last DWORD of a buffer read under 16-byte alignment
    sequence last16_s;
        rx_dword_read && rx_buffer_last && rx_end_align == IRQC_ALIGN_16;
    endsequence

    // Tx status event when above threshold
    tx_stat_a: assert property (@(posedge clock) disable iff (rst)
        (tx_status_used > st_reg.tx_stat_level) |=> irq_event_flags[IRQC_EV_TXSTAT])
        else $error("tx status event missing");

    // Rx status event when above threshold
    rx_stat_a: assert property (@(posedge clock) disable iff (rst)
        (rx_status_used > st_reg.rx_stat_level) |=> irq_event_flags[IRQC_EV_RXSTAT])
        else $error("rx status event missing");

    // Done event on the step from one to zero
    dma_done_a: assert property (@(posedge clock) disable iff (rst)
        (rx_dword_read && st_reg.count_run && rx_dword_countdown == 12'h001)
        |=> irq_event_flags[IRQC_EV_DMADONE])
        else $error("countdown done event missing");

    // Set flags stay until cleared, whatever the mask
    flag_hold_a: assert property (@(posedge clock) disable iff (rst)
        (($past(irq_event_flags) & ~$past(event_clear) & ~irq_event_flags) == 32'h00000000))
        else $error("flag lost without clear");

    // Enable bits store as written, reserved bits dropped
    mask_write_a: assert property (@(posedge clock) disable iff (rst)
        (wr && paddr == IRQC_MASK_OFS) |=> (st_reg.mask == ($past(pwdata) & IRQC_MASK_RW)))
        else $error("mask write not stored");

    // Padding under 32-byte alignment reaches an 8-DWORD boundary
    pad_align32_a: assert property (@(posedge clock) disable iff (rst)
        last32_s |=> (3'(rx_pad_dwords + $past(st_reg.dword_pos) + 3'h1) == 3'h0))
        else $error("32-byte padding wrong");

    // Padding under 16-byte alignment reaches a 4-DWORD boundary
    pad_align16_a: assert property (@(posedge clock) disable iff (rst)
        last16_s |=> (rx_pad_dwords < 3'h4)
        && (2'(rx_pad_dwords + $past(st_reg.dword_pos) + 3'h1) == 2'h0))
        else $error("16-byte padding wrong");

    // Reserved and self-clearing bits of the receive configuration read zero
    rxcfg_reserved_a: assert property (@(posedge clock) disable iff (rst)
        rxcfg_read_s |=> ((prdata & 32'h3000E0FF) == 32'h00000000))
        else $error("receive config reserved bits set");

    // Reserved byte of the level register reads zero
    level_reserved_a: assert property (@(posedge clock) disable iff (rst)
        level_read_s |=> (prdata[15:8] == 8'h00))
        else $error("level reserved byte set");

    // Written offset is used from the next read on
    offset_load_a: assert property (@(posedge clock) disable iff (rst)
        rxcfg_write_s |=> (rx_leading_byte_offset == $past(pwdata[IRQC_OFFSET_LSB +: 5])))
        else $error("offset not taken");

    // Written alignment takes effect from the next cycle, even mid-packet
    align_load_a: assert property (@(posedge clock) disable iff (rst)
        rxcfg_write_s |=> (rx_end_align == $past(pwdata[IRQC_ALIGN_LSB +: 2])))
        else $error("alignment not taken");
endmodule

// ---- inc/irqc_pkg.sv ----
package irqc_pkg;
    // Register byte offsets
    localparam logic [7:0] IRQC_MASK_OFS = 8'h5C;
    localparam logic [7:0] IRQC_PROBE_OFS = 8'h64;
    localparam logic [7:0] IRQC_LEVEL_OFS = 8'h68;
    localparam logic [7:0] IRQC_RXCFG_OFS = 8'h6C;
    // Writable bits of the mask register
    localparam logic [31:0] IRQC_MASK_RW = 32'h83BFE7DF;
    localparam logic [31:0] IRQC_MASK_RST = 32'h00000000;
    // Fixed byte order pattern
    localparam logic [31:0] IRQC_PROBE_VAL = 32'h87654321;
    // Threshold fields
    localparam int IRQC_TXSPACE_LSB = 24;
    localparam int IRQC_TXSTAT_LSB = 16;
    localparam int IRQC_RXSTAT_LSB = 0;
    localparam logic [7:0] IRQC_TXSPACE_RST = 8'h48;
    localparam logic [7:0] IRQC_TXSTAT_RST = 8'h00;
    localparam logic [7:0] IRQC_RXSTAT_RST = 8'h00;
    // Receive configuration fields
    localparam int IRQC_ALIGN_LSB = 30;
    localparam int IRQC_COUNT_LSB = 16;
    localparam int IRQC_DISCARD_BIT = 15;
    localparam int IRQC_OFFSET_LSB = 8;
    // Event bits in the flag vector used by this block
    localparam int IRQC_EV_DMADONE = 20;
    localparam int IRQC_EV_TXSPACE = 9;
    localparam int IRQC_EV_TXSTAT = 7;
    localparam int IRQC_EV_RXSTAT = 3;
    // End alignment choices
    localparam logic [1:0] IRQC_ALIGN_4 = 2'h0;
    localparam logic [1:0] IRQC_ALIGN_16 = 2'h1;
    localparam logic [1:0] IRQC_ALIGN_32 = 2'h2;
    // Pad granule masks in DWORDs, minus one
    localparam logic [2:0] IRQC_PAD16_MASK = 3'h3;
    localparam logic [2:0] IRQC_PAD32_MASK = 3'h7;
endpackage

// ---- sim/irqc_rx_reader.sv ----
`timescale 1ns/1ps
// Host-side reader of the receive data FIFO, one DWORD per cycle
module irqc_rx_reader
(
    // Clock
    input wire logic clock,
    // Burst request
    input wire logic start,
    input wire logic [3:0] count,
    // Read strobes toward the block
    output logic rx_dword_read,
    output logic rx_buffer_last
);
    // DWORDs still to read
    logic [3:0] left_reg = 4'h0;
    // Whole buffers only, so the alignment never changes mid-packet
    always @(posedge clock)
    begin
        if (start)
            left_reg <= count;
        else if (left_reg != 4'h0)
            left_reg <= left_reg - 4'h1;
    end
    assign rx_dword_read = (left_reg != 4'h0);
    assign rx_buffer_last = (left_reg == 4'h1);
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import irqc_pkg::*;
    // Bench signals
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, start = 0;
    logic [7:0] paddr = 8'h00, txf = 8'h00, txs = 8'h00, rxs = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, ev_set = 32'h0, ev_clr = 32'h0, flags, rd;
    logic pready, pslverr, err, irq, disc, rdd, last;
    logic [1:0] algn;
    logic [4:0] ofs;
    logic [2:0] pad;
    logic [11:0] cnt;
    logic [3:0] n_rd = 4'h0;
    int n_mismatch = 0, comparisons = 0, n_disc = 0;
    always #12.5 clock = ~clock;
    // Count discard pulses as they pass
    always @(posedge clock)
        if (disc === 1'b1)
            n_disc <= n_disc + 1;
    irqc_regs u_irqc_regs (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_set(ev_set), .event_clear(ev_clr), .tx_free_blocks(txf),
        .tx_status_used(txs), .rx_status_used(rxs), .rx_dword_read(rdd),
        .rx_buffer_last(last), .irq_event_flags(flags), .irq_out(irq),
        .rx_fifo_discard(disc), .rx_end_align(algn), .rx_leading_byte_offset(ofs),
        .rx_pad_dwords(pad), .rx_dword_countdown(cnt));
    irqc_rx_reader u_irqc_rx_reader (.clock(clock), .start(start), .count(n_rd),
        .rx_dword_read(rdd), .rx_buffer_last(last));
    task end_sim();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready, bounded
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clock);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (i == 20)
        begin
            n_mismatch++;
            end_sim();
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        chk(rd, exp);
    endtask
    task wait_n(input int n);
        repeat (n) @(posedge clock);
    endtask
    // One buffer of n DWORDs; returns the edge after the last read
    task burst(input logic [3:0] n);
        @(posedge clock) {start, n_rd} <= {1'b1, n};
        @(posedge clock) start <= 0;
        wait_n(n + 1);
    endtask
    task t_reset_and_access();
        rchk(IRQC_MASK_OFS, 32'h0);
        rchk(IRQC_PROBE_OFS, 32'h87654321);
        rchk(IRQC_LEVEL_OFS, 32'h48000000);
        rchk(IRQC_RXCFG_OFS, 32'h0);
        apb(1, IRQC_MASK_OFS, 32'hFFFFFFFF);
        rchk(IRQC_MASK_OFS, 32'h83BFE7DF);
        apb(1, IRQC_PROBE_OFS, 32'h0);
        rchk(IRQC_PROBE_OFS, 32'h87654321);
        apb(1, 8'h60, 32'h1);
        chk(err, 1'b1);
        apb(1, IRQC_MASK_OFS, 32'h0);
    endtask
    task t_events();
        @(posedge clock) ev_set <= 32'h1;
        @(posedge clock) ev_set <= 32'h0;
        wait_n(2);
        chk(flags, 32'h1);
        chk(irq, 1'b0);
        apb(1, IRQC_MASK_OFS, 32'h1);
        wait_n(2);
        chk(irq, 1'b1);
        @(posedge clock) ev_clr <= 32'h1;
        @(posedge clock) ev_clr <= 32'h0;
        wait_n(2);
        chk(flags, 32'h0);
        chk(irq, 1'b0);
    endtask
    task t_levels();
        apb(1, IRQC_LEVEL_OFS, 32'h48050002);
        rchk(IRQC_LEVEL_OFS, 32'h48050002);
        txf <= 8'h48;
        txs <= 8'h05;
        rxs <= 8'h02;
        wait_n(3);
        chk(flags, 32'h0);
        txf <= 8'h49;
        txs <= 8'h06;
        rxs <= 8'h03;
        wait_n(3);
        chk(flags, 32'h288);
    endtask
    task t_receive();
        apb(1, IRQC_RXCFG_OFS, 32'h80051300);
        wait_n(1);
        chk({algn, ofs, cnt}, {2'h2, 5'h13, 12'h005});
        burst(4'h2);
        chk(cnt, 12'h003);
        chk(pad, 3'h6);
        apb(1, IRQC_RXCFG_OFS, 32'h40061300);
        rchk(IRQC_RXCFG_OFS, 32'h40061300);
        burst(4'h3);
        chk({cnt, flags[20], pad}, {12'h003, 1'b0, 3'h1});
        burst(4'h3);
        chk({cnt, flags[20], pad}, {12'h000, 1'b1, 3'h1});
        apb(1, IRQC_RXCFG_OFS, 32'h00008000);
        wait_n(2);
        chk(n_disc, 1);
        rchk(IRQC_RXCFG_OFS, 32'h0);
    endtask
    initial
    begin
        repeat (8) @(posedge clock);
        rst <= 0;
        t_reset_and_access();
        t_events();
        t_levels();
        t_receive();
        end_sim();
    end
endmodule
